// ===== hdl/acpc_pkg.sv
// Purpose: constants for the converter configuration and analog pin control block
// Assumes: classic wishbone, 32-bit data, registers in the low byte lane
// Notes: one aligned word per register
// Notes on behaviour
// - bit 7 picks low power over speed
// - bits 6:5 divide source by 1,2,4,8
// - bit 4 picks long sample period
// - bits 3:2 pick 8 or 10 bit
// - bits 1:0 pick converter clock source
// - low pin register covers channels 0-7
// - mid pin register covers channels 8-15
// - set bit removes port control from pin
// - selected pin: driver off, reads zero, no pullup
// - async clock keeps running in wait, stop3
package acpc_pkg;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 8;
    localparam int          CHANNELS      = 16;
    localparam logic [3:0]  OFF_CONFIG    = 4'h0;
    localparam logic [3:0]  OFF_PIN_LOW   = 4'h4;
    localparam logic [3:0]  OFF_PIN_MID   = 4'h8;
    localparam logic [7:0]  RESET_CONFIG  = 8'h00;
    localparam logic [7:0]  RESET_PIN     = 8'h00;
    localparam int          BIT_LOW_POWER = 7;
    localparam int          DIV_HI        = 6;
    localparam int          DIV_LO        = 5;
    localparam int          BIT_LONG_SMP  = 4;
    localparam int          MODE_HI       = 3;
    localparam int          MODE_LO       = 2;
    localparam int          SRC_HI        = 1;
    localparam int          SRC_LO        = 0;
    localparam logic [1:0]  MODE_8BIT     = 2'h0;
    localparam logic [1:0]  MODE_10BIT    = 2'h2;
    localparam logic [1:0]  SRC_BUS       = 2'h0;
    localparam logic [1:0]  SRC_BUS_HALF  = 2'h1;
    localparam logic [1:0]  SRC_ALT       = 2'h2;
    localparam logic [1:0]  SRC_ASYNC     = 2'h3;
    localparam logic [1:0]  DIV_1         = 2'h0;
    localparam logic [1:0]  DIV_8         = 2'h3;
endpackage

// ===== hdl/acpc_clk_if.sv
// Purpose: divider and source fields out, converter clock tick back
// Assumes: both ends run on the bus clock
// Notes: fields come straight from the configuration register
`timescale 1ns/1ns
`default_nettype none
interface acpc_clk_if;
    logic [1:0] clock_divide_field;
    logic [1:0] clock_source_field;
    logic       converter_clock_tick;
    modport ctrl (output clock_divide_field, output clock_source_field, input converter_clock_tick);
    modport gen  (input clock_divide_field, input clock_source_field, output converter_clock_tick);
endinterface
`default_nettype wire

// ===== hdl/acpc_clkgen.sv
// Purpose: converter clock as a tick stream in the bus clock domain
// Assumes: alternate and internal async clock inputs are synchronous levels
// Notes: ticks mark converter clock rising edges
`timescale 1ns/1ns
`default_nettype none
module acpc_clkgen
(
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ce,
    input  wire logic   wait_mode,
    input  wire logic   stop3_mode,
    input  wire logic   alternate_clock,
    input  wire logic   internal_async_clock,
    acpc_clk_if.gen     cif
);
    logic       half_phase;
    logic       alt_prev;
    logic       async_prev;
    logic [2:0] div_cnt;
    logic       tick;

    wire logic       src_async = (cif.clock_source_field == acpc_pkg::SRC_ASYNC);
    // only the internal clock survives low-power modes
    wire logic       run       = ce && (!(wait_mode || stop3_mode) || src_async);
    wire logic       alt_rise  = alternate_clock && !alt_prev;
    wire logic       async_rise = internal_async_clock && !async_prev;
    wire logic [2:0] div_limit = 3'((4'h1 << cif.clock_divide_field) - 4'h1);
    logic            src_tick;

    always_comb
    begin
        case (cif.clock_source_field)
            acpc_pkg::SRC_BUS:      src_tick = 1'b1;
            acpc_pkg::SRC_BUS_HALF: src_tick = half_phase;
            acpc_pkg::SRC_ALT:      src_tick = alt_rise;
            acpc_pkg::SRC_ASYNC:    src_tick = async_rise;
            default:                src_tick = 1'b0;
        endcase
    end

    wire logic div_hit = src_tick && (div_cnt >= div_limit);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            half_phase <= 1'b0;
            alt_prev   <= 1'b0;
            async_prev <= 1'b0;
            div_cnt    <= 3'h0;
            tick       <= 1'b0;
        end
        else if (run)
        begin
            half_phase <= !half_phase;
            alt_prev   <= alternate_clock;
            async_prev <= internal_async_clock;
            div_cnt    <= div_hit ? 3'h0 : (src_tick ? 3'(div_cnt + 3'h1) : div_cnt);
            tick       <= div_hit;
        end
        else
        begin
            tick <= 1'b0;
        end
    end

    assign cif.converter_clock_tick = tick;

    AST_DIV1_BUS: assert property (@(posedge clk) disable iff (rst)
        run && cif.clock_source_field == acpc_pkg::SRC_BUS && cif.clock_divide_field == acpc_pkg::DIV_1 |=> tick)
        else $error("bus source undivided missed a tick");
    AST_DIV_GAP: assert property (@(posedge clk) disable iff (rst)
        tick && cif.clock_divide_field != acpc_pkg::DIV_1 |=> !tick)
        else $error("divided clock ticked twice in a row");
    AST_GATED_LOWPOW: assert property (@(posedge clk) disable iff (rst)
        (wait_mode || stop3_mode) && !src_async |=> !tick)
        else $error("non-async source ticked in low-power mode");
    AST_ASYNC_STOP: assert property (@(posedge clk) disable iff (rst)
        ce && stop3_mode && src_async && async_rise && cif.clock_divide_field == acpc_pkg::DIV_1 |=> tick)
        else $error("async clock stopped in stop3");
endmodule
`default_nettype wire

// ===== hdl/acpc_top.sv
// Purpose: configuration and analog pin control registers on classic wishbone
// Assumes: port logic and pads are synchronous to clk
// Notes: registers sit in byte lane 0, upper bits read zero
`timescale 1ns/1ns
`default_nettype none
module acpc_top
#(
    parameter int CHANNELS = acpc_pkg::CHANNELS
)
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [acpc_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [acpc_pkg::DATA_W-1:0] wb_dat_i,
    output logic [acpc_pkg::DATA_W-1:0]      wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic                        wait_mode,
    input  wire logic                        stop3_mode,
    input  wire logic                        alternate_clock,
    input  wire logic                        internal_async_clock,
    output logic                             low_power_select,
    output logic                             long_sample_select,
    output logic                             ten_bit_mode,
    output logic [1:0]                       clock_source_field,
    output logic [1:0]                       clock_divide_field,
    output logic                             converter_clock_tick,
    output logic [CHANNELS-1:0]              analog_select,
    input  wire logic [CHANNELS-1:0]         port_out,
    input  wire logic [CHANNELS-1:0]         port_oe,
    input  wire logic [CHANNELS-1:0]         port_pullup,
    output logic [CHANNELS-1:0]              port_in,
    input  wire logic [CHANNELS-1:0]         pad_in,
    output logic [CHANNELS-1:0]              pad_out,
    output logic [CHANNELS-1:0]              pad_oe,
    output logic [CHANNELS-1:0]              pad_pullup
);
    logic [7:0]                  converter_configuration;
    logic [7:0]                  analog_pin_select_low;
    logic [7:0]                  analog_pin_select_mid;
    logic                        ack;
    logic [acpc_pkg::DATA_W-1:0] rdata_q;

    acpc_clk_if cif ();

    wire logic req       = wb_cyc_i && wb_stb_i;
    wire logic hit_cfg   = (wb_adr_i == acpc_pkg::OFF_CONFIG);
    wire logic hit_low   = (wb_adr_i == acpc_pkg::OFF_PIN_LOW);
    wire logic hit_mid   = (wb_adr_i == acpc_pkg::OFF_PIN_MID);
    // write lands on the ack edge, when the master sees the answer
    wire logic wr_byte   = ce && req && ack && wb_we_i && wb_sel_i[0];
    wire logic wr_cfg    = wr_byte && hit_cfg;
    wire logic wr_low    = wr_byte && hit_low;
    wire logic wr_mid    = wr_byte && hit_mid;
    // unmapped reads answer zero, unmapped writes are dropped
    wire logic [7:0] rd_byte = hit_cfg ? converter_configuration :
                               hit_low ? analog_pin_select_low :
                               hit_mid ? analog_pin_select_mid : 8'h00;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack     <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ack <= req && !ack;
            if (req && !ack)
            begin
                rdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            converter_configuration <= acpc_pkg::RESET_CONFIG;
            analog_pin_select_low   <= acpc_pkg::RESET_PIN;
            analog_pin_select_mid   <= acpc_pkg::RESET_PIN;
        end
        else
        begin
            if (wr_cfg)
            begin
                converter_configuration <= wb_dat_i[7:0];
            end
            if (wr_low)
            begin
                analog_pin_select_low <= wb_dat_i[7:0];
            end
            if (wr_mid)
            begin
                analog_pin_select_mid <= wb_dat_i[7:0];
            end
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata_q;

    assign low_power_select   = converter_configuration[acpc_pkg::BIT_LOW_POWER];
    assign clock_divide_field = converter_configuration[acpc_pkg::DIV_HI:acpc_pkg::DIV_LO];
    assign long_sample_select = converter_configuration[acpc_pkg::BIT_LONG_SMP];
    // reserved mode codes fall back to 8-bit
    assign ten_bit_mode       = converter_configuration[acpc_pkg::MODE_HI:acpc_pkg::MODE_LO]
                                == acpc_pkg::MODE_10BIT;
    assign clock_source_field = converter_configuration[acpc_pkg::SRC_HI:acpc_pkg::SRC_LO];

    assign cif.clock_divide_field = clock_divide_field;
    assign cif.clock_source_field = clock_source_field;
    assign converter_clock_tick   = cif.converter_clock_tick;

    acpc_clkgen u_clkgen
    (
        .clk                  (clk),
        .rst                  (rst),
        .ce                   (ce),
        .wait_mode            (wait_mode),
        .stop3_mode           (stop3_mode),
        .alternate_clock      (alternate_clock),
        .internal_async_clock (internal_async_clock),
        .cif                  (cif)
    );

    // channels above 15 have no select register and stay under port control
    wire logic [15:0] sel_bits = {analog_pin_select_mid, analog_pin_select_low};

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_pin
            wire logic sel = (ch < 16) ? sel_bits[ch % 16] : 1'b0;
            assign analog_select[ch] = sel;
            assign pad_out[ch]       = sel ? 1'b0 : port_out[ch];
            assign pad_oe[ch]        = sel ? 1'b0 : port_oe[ch];
            assign port_in[ch]       = sel ? 1'b0 : pad_in[ch];
            assign pad_pullup[ch]    = sel ? 1'b0 : port_pullup[ch];

            AST_PIN_FORCED: assert property (@(posedge clk) disable iff (rst)
                sel |-> !pad_oe[ch] && !port_in[ch] && !pad_pullup[ch])
                else $error("analog pin not isolated from port");
            AST_PIN_PASS: assert property (@(posedge clk) disable iff (rst)
                !sel |-> pad_oe[ch] == port_oe[ch] && port_in[ch] == pad_in[ch])
                else $error("port control lost on digital pin");
            AST_PAD_OUT_OFF: assert property (@(posedge clk) disable iff (rst)
                sel |-> !pad_out[ch])
                else $error("analog pin still driving port data");
            AST_PULL_PASS: assert property (@(posedge clk) disable iff (rst)
                !sel |-> pad_pullup[ch] == port_pullup[ch] && pad_out[ch] == port_out[ch])
                else $error("port pullup or data lost on digital pin");
        end
    endgenerate

    AST_ACK_ANSWER: assert property (@(posedge clk) disable iff (rst)
        ce && req && !ack |=> ack ##1 !ack)
        else $error("bus answer not one cycle after request");
    AST_CFG_WRITE: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> converter_configuration == $past(wb_dat_i[7:0]))
        else $error("configuration write not stored");
    AST_MID_MAP: assert property (@(posedge clk) disable iff (rst)
        wr_mid |=> analog_select[15] == $past(wb_dat_i[7]) && analog_select[8] == $past(wb_dat_i[0]))
        else $error("mid pin register mapped wrong");
    AST_LOW_MAP: assert property (@(posedge clk) disable iff (rst)
        wr_low |=> analog_select[7:0] == $past(wb_dat_i[7:0]))
        else $error("low pin register mapped wrong");
    AST_READBACK: assert property (@(posedge clk) disable iff (rst)
        ce && req && !ack && !wb_we_i && hit_mid |=> wb_dat_o == {24'h00_0000, analog_pin_select_mid})
        else $error("mid pin register read back wrong");
    AST_RESET_ZERO: assert property (@(posedge clk)
        $past(rst) && !rst |-> converter_configuration == 8'h00 && sel_bits == 16'h0000)
        else $error("registers not zero after reset");
    AST_MODE_10: assert property (@(posedge clk) disable iff (rst)
        wr_cfg && wb_dat_i[3:2] == 2'h2 |=> ten_bit_mode ##1 (ten_bit_mode || $past(wr_cfg)))
        else $error("10-bit code did not select 10-bit mode");
    AST_LOW_POWER: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> low_power_select == $past(wb_dat_i[7]))
        else $error("low power select not following write");

    // a low enable holds the bus side and silences the tick
    AST_CE_FREEZE: assert property (@(posedge clk) disable iff (rst)
        !ce |=> ack == $past(ack) && wb_dat_o == $past(wb_dat_o) && $stable(converter_configuration)
                && !converter_clock_tick)
        else $error("state moved while clock enable was low");
    AST_ACK_IDLE: assert property (@(posedge clk) disable iff (rst)
        ce && !req |=> !ack)
        else $error("answer given with no request");
    AST_LANE_OFF: assert property (@(posedge clk) disable iff (rst)
        req && ack && wb_we_i && !wb_sel_i[0] |=> $stable(converter_configuration) && $stable(sel_bits))
        else $error("write with low lane off changed a register");
    AST_UNMAPPED_DROP: assert property (@(posedge clk) disable iff (rst)
        req && ack && wb_we_i && !(hit_cfg || hit_low || hit_mid)
        |=> $stable(converter_configuration) && $stable(sel_bits))
        else $error("unmapped write changed a register");
    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (rst)
        ce && req && !ack && !wb_we_i && !(hit_cfg || hit_low || hit_mid) |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_CFG_READ: assert property (@(posedge clk) disable iff (rst)
        ce && req && !ack && !wb_we_i && hit_cfg |=> wb_dat_o == {24'h00_0000, converter_configuration})
        else $error("configuration read back wrong");
    AST_LOW_READ: assert property (@(posedge clk) disable iff (rst)
        ce && req && !ack && !wb_we_i && hit_low |=> wb_dat_o == {24'h00_0000, analog_pin_select_low})
        else $error("low pin register read back wrong");
    AST_LONG_SAMPLE: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> long_sample_select == $past(wb_dat_i[acpc_pkg::BIT_LONG_SMP]))
        else $error("long sample select not following write");
    AST_SRC_FIELD: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> clock_source_field == $past(wb_dat_i[acpc_pkg::SRC_HI:acpc_pkg::SRC_LO]))
        else $error("clock source field not following write");
    AST_DIV_FIELD: assert property (@(posedge clk) disable iff (rst)
        wr_cfg |=> clock_divide_field == $past(wb_dat_i[acpc_pkg::DIV_HI:acpc_pkg::DIV_LO]))
        else $error("clock divide field not following write");
    AST_MODE_8: assert property (@(posedge clk) disable iff (rst)
        wr_cfg && wb_dat_i[acpc_pkg::MODE_HI:acpc_pkg::MODE_LO] != acpc_pkg::MODE_10BIT |=> !ten_bit_mode)
        else $error("non 10-bit code selected 10-bit mode");
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: self-checking bench for the converter configuration and pin control block
// Assumes: wishbone ack one cycle after the request is taken; ce held high except in the low enable test
// Notes: source clocks come from bench toggles; alternate period 2, async period 4
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk, rst, ce, cyc, stb, we, wait_m, stop3, alt_clk, async_clk, ack;
    logic        lp, ls, ten, tick;
    logic [3:0]  adr, sel, ph;
    logic [31:0] dat_w, dat_r, d;
    logic [1:0]  src, div;
    logic [15:0] asel, p_out, p_oe, p_pu, p_in, pd_in, pd_out, pd_oe, pd_pu, pv;
    logic [7:0]  v;
    int          fails, n_checks, n;
    int          per[4] = '{1, 2, 2, 4};

    acpc_top u_acpc_top (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .wait_mode(wait_m), .stop3_mode(stop3), .alternate_clock(alt_clk), .internal_async_clock(async_clk),
        .low_power_select(lp), .long_sample_select(ls), .ten_bit_mode(ten), .clock_source_field(src),
        .clock_divide_field(div), .converter_clock_tick(tick), .analog_select(asel), .port_out(p_out),
        .port_oe(p_oe), .port_pullup(p_pu), .port_in(p_in), .pad_in(pd_in), .pad_out(pd_out),
        .pad_oe(pd_oe), .pad_pullup(pd_pu));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // free-running stand-ins for the slow clock sources
    // held low in reset so no false source edge follows release
    always @(posedge clk)
    begin
        if (rst)
        begin
            alt_clk   <= 1'b0;
            async_clk <= 1'b0;
            ph        <= 4'h0;
        end
        else
        begin
            alt_clk <= ~alt_clk;
            ph      <= ph + 4'h1;
            if (ph[0])
            begin
                async_clk <= ~async_clk;
            end
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        n_checks++;
        if (got != exp)
        begin
            fails++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // one classic cycle; holds everything until ack is sampled at a rising edge
    task automatic wb_cycle(input logic w, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] s);
        int t;
        t = 0;
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= wd;
        sel   <= s;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (ack !== 1'b1);
        check_count("ack latency", 2, t);
        d = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic reg_check(input string what, input logic [3:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0, 4'hF);
        check(what, exp, d);
    endtask

    // window of 64 cycles after the divider has settled; unknown ticks must not pass as zero
    task automatic tally(input int exp);
        repeat (24) @(negedge clk);
        n = 0;
        repeat (64)
        begin
            @(negedge clk);
            n += (tick === 1'b1) ? 1 : ((tick === 1'b0) ? 0 : 1000);
        end
        check_count("tick count", exp, n);
    endtask

    task automatic count_ticks(input logic [7:0] cfg, input int exp);
        wb_cycle(1'b1, acpc_pkg::OFF_CONFIG, {24'h0, cfg}, 4'hF);
        tally(exp);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        fails++;
        print_verdict;
    end

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'h0;
        dat_w = 32'h0;
        wait_m = 1'b0;
        stop3 = 1'b0;
        p_out = 16'h0;
        p_oe = 16'h0;
        p_pu = 16'h0;
        pd_in = 16'h0;
        fails = 0;
        n_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reg_check("config reset", acpc_pkg::OFF_CONFIG, 32'h0);
        reg_check("pin low reset", acpc_pkg::OFF_PIN_LOW, 32'h0);
        reg_check("pin mid reset", acpc_pkg::OFF_PIN_MID, 32'h0);
        check("select reset", 32'h0, {16'h0, asel});
        // every configuration code, reserved modes included
        for (int i = 0; i < 256; i++)
        begin
            v = i[7:0];
            wb_cycle(1'b1, acpc_pkg::OFF_CONFIG, {24'hA5C3F0, v}, 4'hF);
            @(negedge clk);
            check("low power", {31'h0, v[7]}, {31'h0, lp});
            check("divide field", {30'h0, v[6:5]}, {30'h0, div});
            check("long sample", {31'h0, v[4]}, {31'h0, ls});
            check("ten bit", {31'h0, v[3:2] == 2'h2}, {31'h0, ten});
            check("source field", {30'h0, v[1:0]}, {30'h0, src});
            reg_check("config read", acpc_pkg::OFF_CONFIG, {24'h0, v});
        end
        // low lane disabled and unmapped place leave the register alone
        wb_cycle(1'b1, acpc_pkg::OFF_CONFIG, 32'h8A, 4'hF);
        wb_cycle(1'b1, acpc_pkg::OFF_CONFIG, 32'h55, 4'hE);
        wb_cycle(1'b1, 4'hC, 32'hFF, 4'hF);
        reg_check("unmapped read", 4'hC, 32'h0);
        reg_check("config kept", acpc_pkg::OFF_CONFIG, 32'h8A);
        // every source against every divider
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 4; k++)
                count_ticks({1'b0, k[1:0], 3'h0, s[1:0]}, 64 / (per[s] * (1 << k)));
        // only the async source survives wait and the third stop mode
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            wait_m <= (m == 0);
            stop3 <= (m == 1);
            count_ticks(8'h00, 0);
            count_ticks(8'h03, 16);
        end
        @(posedge clk);
        wait_m <= 1'b0;
        stop3 <= 1'b0;
        // low enable stops even the async source
        @(posedge clk);
        ce <= 1'b0;
        tally(0);
        @(posedge clk);
        ce <= 1'b1;
        // pin control, each pattern against its complement
        for (int r = 0; r < 2; r++)
        begin
            v = (r == 0) ? 8'hA5 : 8'h5A;
            wb_cycle(1'b1, acpc_pkg::OFF_PIN_LOW, {24'h0, v}, 4'hF);
            wb_cycle(1'b1, acpc_pkg::OFF_PIN_MID, {24'h0, ~v ^ 8'h0F}, 4'hF);
            reg_check("pin low read", acpc_pkg::OFF_PIN_LOW, {24'h0, v});
            reg_check("pin mid read", acpc_pkg::OFF_PIN_MID, {24'h0, ~v ^ 8'h0F});
            check("select map", {16'h0, ~v ^ 8'h0F, v}, {16'h0, asel});
            for (int q = 0; q < 2; q++)
            begin
                pv = (q == 0) ? 16'hFFFF : 16'h96C3;
                @(posedge clk);
                p_out <= pv;
                p_oe  <= pv;
                p_pu  <= ~pv;
                pd_in <= pv;
                @(negedge clk);
                check("pad out", {16'h0, pv & ~asel}, {16'h0, pd_out});
                check("pad enable", {16'h0, pv & ~asel}, {16'h0, pd_oe});
                check("pad pullup", {16'h0, ~pv & ~asel}, {16'h0, pd_pu});
                check("port read", {16'h0, pv & ~asel}, {16'h0, p_in});
            end
        end
        // second reset in mid-run clears the registers again; pads go back to following the port
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        check("select rereset", 32'h0, {16'h0, asel});
        check("pad out rereset", {16'h0, pv}, {16'h0, pd_out});
        @(posedge clk);
        rst <= 1'b0;
        reg_check("config rereset", acpc_pkg::OFF_CONFIG, 32'h0);
        reg_check("pin mid rereset", acpc_pkg::OFF_PIN_MID, 32'h0);
        print_verdict;
    end
endmodule
`default_nettype wire
